// ==== src/sos_pkg.sv ====
// Package: register map, field positions and test port states for the status output selector
package sos_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SOS_ADDR_GENERAL_CONTROL  = 8'h00;
    localparam logic [7:0] SOS_ADDR_OUTPUT_STATUS    = 8'h02;
    localparam logic [7:0] SOS_ADDR_TX_SECTION_CTRL  = 8'h0c;
    localparam logic [7:0] SOS_ADDR_TX_LINE_CTRL     = 8'h0d;
    localparam logic [7:0] SOS_ADDR_RX_LINE_CTRL     = 8'h46;
    localparam logic [7:0] SOS_ADDR_IRQ_STATUS       = 8'h80;
    localparam logic [7:0] SOS_ADDR_IRQ_MASK         = 8'h81;
    localparam logic [7:0] SOS_ADDR_SCAN_ID          = 8'h82;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SOS_GEN_DEFECT_SEL_BIT = 2;
    localparam int SOS_RXL_SECTION_BIT    = 0;
    localparam int SOS_RXL_LINE_BIT       = 1;
    localparam int SOS_TXL_DL_BIT         = 4;
    localparam int SOS_TXS_DL_BIT         = 6;
    localparam int SOS_IRQ_BITS           = 4;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SOS_RESET_REG  = 8'h00;
    localparam logic [7:0] SOS_UNMAPPED   = 8'h00;
    // Arbitrary neutral scan identification value
    localparam logic [31:0] SOS_SCAN_IDCODE = 32'h00000001;
    localparam logic [3:0]  SOS_IR_IDCODE   = 4'h1;
    localparam logic [3:0]  SOS_IR_BYPASS   = 4'hf;
    localparam int          SOS_IR_W        = 4;
    // ------------------------------------------------------------
    // Test port controller states
    // ------------------------------------------------------------
    typedef enum logic [15:0] {
        SOS_TAP_RESET = 16'h0001, SOS_TAP_IDLE  = 16'h0002,
        SOS_TAP_SELDR = 16'h0004, SOS_TAP_CAPDR = 16'h0008,
        SOS_TAP_SHDR  = 16'h0010, SOS_TAP_EX1DR = 16'h0020,
        SOS_TAP_PSDR  = 16'h0040, SOS_TAP_EX2DR = 16'h0080,
        SOS_TAP_UPDR  = 16'h0100, SOS_TAP_SELIR = 16'h0200,
        SOS_TAP_CAPIR = 16'h0400, SOS_TAP_SHIR  = 16'h0800,
        SOS_TAP_EX1IR = 16'h1000, SOS_TAP_PSIR  = 16'h2000,
        SOS_TAP_EX2IR = 16'h4000, SOS_TAP_UPIR  = 16'h8000
    } sos_tap_state_t;
endpackage : sos_pkg

// ==== src/sos_tap.sv ====
// Boundary-scan test port controller with bypass and identification registers
`timescale 1ns/100ps
module sos_tap (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic tck_rise,
    input  wire logic tck_fall,
    input  wire logic trst_n_s,
    input  wire logic tms_s,
    input  wire logic tdi_s,
    output logic      tdo_q,
    output logic      tdo_oe_n_q,
    output logic      tap_in_reset
);
    import sos_pkg::*;

    sos_tap_state_t          state_q;
    sos_tap_state_t          state_d;
    logic [SOS_IR_W-1:0]     ir_q;
    logic [SOS_IR_W-1:0]     ir_sh_q;
    logic [31:0]             dr_q;
    logic                    tdo_bit;

    // ------------------------------------------------------------
    // State transitions
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            SOS_TAP_RESET: state_d = tms_s ? SOS_TAP_RESET : SOS_TAP_IDLE;
            SOS_TAP_IDLE:  state_d = tms_s ? SOS_TAP_SELDR : SOS_TAP_IDLE;
            SOS_TAP_SELDR: state_d = tms_s ? SOS_TAP_SELIR : SOS_TAP_CAPDR;
            SOS_TAP_CAPDR: state_d = tms_s ? SOS_TAP_EX1DR : SOS_TAP_SHDR;
            SOS_TAP_SHDR:  state_d = tms_s ? SOS_TAP_EX1DR : SOS_TAP_SHDR;
            SOS_TAP_EX1DR: state_d = tms_s ? SOS_TAP_UPDR  : SOS_TAP_PSDR;
            SOS_TAP_PSDR:  state_d = tms_s ? SOS_TAP_EX2DR : SOS_TAP_PSDR;
            SOS_TAP_EX2DR: state_d = tms_s ? SOS_TAP_UPDR  : SOS_TAP_SHDR;
            SOS_TAP_UPDR:  state_d = tms_s ? SOS_TAP_SELDR : SOS_TAP_IDLE;
            SOS_TAP_SELIR: state_d = tms_s ? SOS_TAP_RESET : SOS_TAP_CAPIR;
            SOS_TAP_CAPIR: state_d = tms_s ? SOS_TAP_EX1IR : SOS_TAP_SHIR;
            SOS_TAP_SHIR:  state_d = tms_s ? SOS_TAP_EX1IR : SOS_TAP_SHIR;
            SOS_TAP_EX1IR: state_d = tms_s ? SOS_TAP_UPIR  : SOS_TAP_PSIR;
            SOS_TAP_PSIR:  state_d = tms_s ? SOS_TAP_EX2IR : SOS_TAP_PSIR;
            SOS_TAP_EX2IR: state_d = tms_s ? SOS_TAP_UPIR  : SOS_TAP_SHIR;
            SOS_TAP_UPIR:  state_d = tms_s ? SOS_TAP_SELDR : SOS_TAP_IDLE;
            default:       state_d = SOS_TAP_RESET;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !trst_n_s)                 // [R1]
            state_q <= SOS_TAP_RESET;
        else if (tck_rise)                       // [R2]
            state_q <= state_d;                  // [R3]
    end

    // ------------------------------------------------------------
    // Instruction and data registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !trst_n_s || state_q == SOS_TAP_RESET)  // [R1]
        begin
            ir_q    <= SOS_IR_IDCODE;
            ir_sh_q <= SOS_IR_IDCODE;
            dr_q    <= 32'h00000000;
        end
        else if (tck_rise)                                    // [R2]
        begin
            unique case (state_q)
                SOS_TAP_CAPIR: ir_sh_q <= SOS_IR_IDCODE;
                SOS_TAP_SHIR:  ir_sh_q <= {tdi_s, ir_sh_q[SOS_IR_W-1:1]};   // [R4]
                SOS_TAP_UPIR:  ir_q    <= ir_sh_q;
                SOS_TAP_CAPDR: dr_q    <= (ir_q == SOS_IR_IDCODE) ? SOS_SCAN_IDCODE
                                                                  : 32'h00000000;
                SOS_TAP_SHDR:  dr_q    <= (ir_q == SOS_IR_IDCODE) ? {tdi_s, dr_q[31:1]}
                                                                  : {31'h0, tdi_s}; // [R4]
                default:       dr_q    <= dr_q;
            endcase
        end
    end

    assign tdo_bit      = (state_q == SOS_TAP_SHIR) ? ir_sh_q[0] : dr_q[0];
    assign tap_in_reset = (state_q == SOS_TAP_RESET);

    // ------------------------------------------------------------
    // Serial output, changed on the falling test clock edge
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !trst_n_s)                 // [R1]
        begin
            tdo_q      <= 1'b0;
            tdo_oe_n_q <= 1'b1;
        end
        else if (tck_fall)
        begin
            tdo_q      <= tdo_bit;                                           // [R4]
            tdo_oe_n_q <= !(state_q == SOS_TAP_SHIR || state_q == SOS_TAP_SHDR);
        end
    end
endmodule : sos_tap

// ==== src/sos_top.sv ====
// Status output selector: upper status pins, register port, test port
//
// Behaviour
// R1 - Test reset low returns the boundary-scan logic to its reset state.
// R2 - Test mode and data input are sampled on each test clock rising edge.
// R3 - Test mode select steers the test port controller state transitions.
// R4 - Scan data enters on the first port input, leaves on the last.
// R5 - Status pin 7 shows output bit 7 or loss of signal, general bit 2.
// R6 - Receive line bits 0 or 1 route receive data link clock to pin 7.
// R7 - Status pin 6 shows output bit 6 or out of frame, general bit 2.
// R8 - Receive line bits 0 or 1 route receive data link data to pin 6.
// R9 - Status pin 5 shows output bit 5 or loss of pointer, general bit 2.
// R10 - Pin 5 in receive data link mode marks early or late octet group.
// R11 - Status pin 4 shows output bit 4 or line alarm, general bit 2.
// R12 - Transmit line bit 4 or section bit 6 route transmit clock to pin 4.
// R13 - Data link routing takes priority over the general bit choice.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
module sos_top (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            irq,
    input  wire logic       los_defect,
    input  wire logic       oof_defect,
    input  wire logic       lop_defect,
    input  wire logic       ais_line_defect,
    input  wire logic       rx_dl_clk,
    input  wire logic       rx_dl_data,
    input  wire logic       rx_dl_early_group,
    input  wire logic       tx_dl_clk,
    output logic      [3:0] status_pins,
    input  wire logic       trst_n,
    input  wire logic       tck,
    input  wire logic       tms,
    input  wire logic       tdi,
    output logic            tdo,
    output logic            tdo_oe_n
);
    import sos_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 12;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic             tck_prev_q;

    assign async_in = {los_defect, oof_defect, lop_defect, ais_line_defect,
                       rx_dl_clk, rx_dl_data, rx_dl_early_group, tx_dl_clk,
                       trst_n, tck, tms, tdi};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++)
        begin : g_sync
            always_ff @(posedge clk_sys)
            begin
                if (!rst_n)
                begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end
                else
                begin
                    sync1_q[gi] <= async_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    logic los_s, oof_s, lop_s, ais_s, rxc_s, rxd_s, rxi_s, txc_s;
    logic trst_n_s, tck_s, tms_s, tdi_s;
    assign {los_s, oof_s, lop_s, ais_s, rxc_s, rxd_s, rxi_s, txc_s,
            trst_n_s, tck_s, tms_s, tdi_s} = sync2_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            tck_prev_q <= 1'b0;
        else
            tck_prev_q <= tck_s;
    end

    logic tck_rise;
    logic tck_fall;
    assign tck_rise = tck_s && !tck_prev_q;
    assign tck_fall = !tck_s && tck_prev_q;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]              gen_q;
    logic [7:0]              output_status_bits_q;
    logic [7:0]              transmit_section_control_q;
    logic [7:0]              transmit_line_control_q;
    logic [7:0]              receive_line_control_q;
    logic [SOS_IRQ_BITS-1:0] irq_stat_q;
    logic [SOS_IRQ_BITS-1:0] irq_mask_q;
    logic [SOS_IRQ_BITS-1:0] defect_prev_q;
    logic                    tap_in_reset;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            gen_q     <= SOS_RESET_REG;
            output_status_bits_q <= SOS_RESET_REG;
            transmit_section_control_q   <= SOS_RESET_REG;
            transmit_line_control_q   <= SOS_RESET_REG;
            receive_line_control_q   <= SOS_RESET_REG;
        end
        else if (reg_wr)
        begin
            if (hit(reg_addr, SOS_ADDR_GENERAL_CONTROL))
                gen_q <= reg_wdata;
            if (hit(reg_addr, SOS_ADDR_OUTPUT_STATUS))
                output_status_bits_q <= reg_wdata;
            if (hit(reg_addr, SOS_ADDR_TX_SECTION_CTRL))
                transmit_section_control_q <= reg_wdata;
            if (hit(reg_addr, SOS_ADDR_TX_LINE_CTRL))
                transmit_line_control_q <= reg_wdata;
            if (hit(reg_addr, SOS_ADDR_RX_LINE_CTRL))
                receive_line_control_q <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // Defect interrupts
    // ------------------------------------------------------------
    logic [SOS_IRQ_BITS-1:0] defects;
    logic [SOS_IRQ_BITS-1:0] defect_rise;
    logic [SOS_IRQ_BITS-1:0] irq_clr;
    assign defects     = {los_s, oof_s, lop_s, ais_s};
    assign defect_rise = defects & ~defect_prev_q;
    assign irq_clr     = (reg_wr && hit(reg_addr, SOS_ADDR_IRQ_STATUS))
                         ? reg_wdata[SOS_IRQ_BITS-1:0] : '0;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            defect_prev_q <= '0;
            irq_stat_q    <= '0;
            irq_mask_q    <= '0;
            irq           <= 1'b0;
        end
        else
        begin
            defect_prev_q <= defects;
            irq_stat_q    <= (irq_stat_q & ~irq_clr) | defect_rise;
            if (reg_wr && hit(reg_addr, SOS_ADDR_IRQ_MASK))
                irq_mask_q <= reg_wdata[SOS_IRQ_BITS-1:0];
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            reg_rdata <= SOS_UNMAPPED;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                SOS_ADDR_GENERAL_CONTROL: reg_rdata <= gen_q;
                SOS_ADDR_OUTPUT_STATUS:   reg_rdata <= output_status_bits_q;
                SOS_ADDR_TX_SECTION_CTRL: reg_rdata <= transmit_section_control_q;
                SOS_ADDR_TX_LINE_CTRL:    reg_rdata <= transmit_line_control_q;
                SOS_ADDR_RX_LINE_CTRL:    reg_rdata <= receive_line_control_q;
                SOS_ADDR_IRQ_STATUS:      reg_rdata <= {4'h0, irq_stat_q};
                SOS_ADDR_IRQ_MASK:        reg_rdata <= {4'h0, irq_mask_q};
                SOS_ADDR_SCAN_ID:         reg_rdata <= {7'h00, tap_in_reset};
                default:                  reg_rdata <= SOS_UNMAPPED;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status pin selection
    // ------------------------------------------------------------
    logic       defect_sel;
    logic       rx_dl_sel;
    logic       tx_dl_sel;
    logic [3:0] pins_d;

    assign defect_sel = gen_q[SOS_GEN_DEFECT_SEL_BIT];
    assign rx_dl_sel  = receive_line_control_q[SOS_RXL_SECTION_BIT] || receive_line_control_q[SOS_RXL_LINE_BIT];
    assign tx_dl_sel  = transmit_line_control_q[SOS_TXL_DL_BIT] || transmit_section_control_q[SOS_TXS_DL_BIT];

    always_comb
    begin
        pins_d[3] = defect_sel ? los_s : output_status_bits_q[7];        // [R5]
        pins_d[2] = defect_sel ? oof_s : output_status_bits_q[6];        // [R7]
        pins_d[1] = defect_sel ? lop_s : output_status_bits_q[5];        // [R9]
        pins_d[0] = defect_sel ? ais_s : output_status_bits_q[4];        // [R11]
        if (rx_dl_sel)                                        // [R13]
        begin
            pins_d[3] = rxc_s;                                // [R6]
            pins_d[2] = rxd_s;                                // [R8]
            pins_d[1] = rxi_s;                                // [R10]
        end
        if (tx_dl_sel)                                        // [R13]
            pins_d[0] = txc_s;                                // [R12]
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            status_pins <= 4'h0;
        else
            status_pins <= pins_d;
    end

    // ------------------------------------------------------------
    // Test port
    // ------------------------------------------------------------
    sos_tap u_tap (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .tck_rise     (tck_rise),
        .tck_fall     (tck_fall),
        .trst_n_s     (trst_n_s),
        .tms_s        (tms_s),
        .tdi_s        (tdi_s),
        .tdo_q        (tdo),
        .tdo_oe_n_q   (tdo_oe_n),
        .tap_in_reset (tap_in_reset)
    );
endmodule : sos_top

// ==== sim/sos_props.sv ====
// Port checker for the status output selector
`timescale 1ns/100ps
module sos_props
    import sos_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       irq,
    input wire logic       los_defect,
    input wire logic       oof_defect,
    input wire logic       lop_defect,
    input wire logic       ais_line_defect,
    input wire logic       rx_dl_clk,
    input wire logic       rx_dl_data,
    input wire logic       rx_dl_early_group,
    input wire logic       tx_dl_clk,
    input wire logic [3:0] status_pins,
    input wire logic       trst_n,
    input wire logic       tck,
    input wire logic       tdo,
    input wire logic       tdo_oe_n
);
    logic [7:0] gen_q, os_q, txs_q, txl_q, rxl_q, s1_q, s2_q, s3_q, rexp;
    logic [3:0] st_q, mk_q, dsel, e;
    // ----
    // Shadow state
    // ----
    always_ff @(posedge clk_sys)
    begin
        s1_q <= {los_defect, oof_defect, lop_defect, ais_line_defect,
                 rx_dl_clk, rx_dl_data, rx_dl_early_group, tx_dl_clk};
        s2_q <= s1_q;
        s3_q <= s2_q;
    end
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            {gen_q, os_q, txs_q, txl_q, rxl_q, mk_q} <= 44'h0;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                SOS_ADDR_GENERAL_CONTROL: gen_q <= reg_wdata;
                SOS_ADDR_OUTPUT_STATUS:   os_q  <= reg_wdata;
                SOS_ADDR_TX_SECTION_CTRL: txs_q <= reg_wdata;
                SOS_ADDR_TX_LINE_CTRL:    txl_q <= reg_wdata;
                SOS_ADDR_RX_LINE_CTRL:    rxl_q <= reg_wdata;
                SOS_ADDR_IRQ_MASK:        mk_q  <= reg_wdata[3:0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            st_q <= 4'h0;
        else
            st_q <= (st_q & ~((reg_wr && reg_addr == SOS_ADDR_IRQ_STATUS) ? reg_wdata[3:0]
                    : 4'h0)) | (s2_q[7:4] & ~s3_q[7:4]);
    end
    always_comb
    begin
        dsel = gen_q[SOS_GEN_DEFECT_SEL_BIT] ? s2_q[7:4] : os_q[7:4];
        e = {(|rxl_q[1:0]) ? s2_q[3:1] : dsel[3:1],
             (txl_q[SOS_TXL_DL_BIT] | txs_q[SOS_TXS_DL_BIT]) ? s2_q[0] : dsel[0]};
        case (reg_addr)
            SOS_ADDR_GENERAL_CONTROL: rexp = gen_q;
            SOS_ADDR_OUTPUT_STATUS:   rexp = os_q;
            SOS_ADDR_TX_SECTION_CTRL: rexp = txs_q;
            SOS_ADDR_TX_LINE_CTRL:    rexp = txl_q;
            SOS_ADDR_RX_LINE_CTRL:    rexp = rxl_q;
            default:                  rexp = 8'h00;
        endcase
    end
    // ----
    // Assertions
    // ----
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_pin7_select: assert property (status_pins[3] == $past(e[3]))
        else $error("pin 7 source wrong");
    a_pin6_select: assert property (status_pins[2] == $past(e[2]))
        else $error("pin 6 source wrong");
    a_pin5_select: assert property (status_pins[1] == $past(e[1]))
        else $error("pin 5 source wrong");
    a_pin4_select: assert property (status_pins[0] == $past(e[0]))
        else $error("pin 4 source wrong");
    a_irq_level: assert property (irq == $past(|(st_q & mk_q)))
        else $error("irq level wrong");
    a_read_data: assert property (reg_rd && reg_addr < 8'h80 |=> reg_rdata == $past(rexp))
        else $error("read data wrong");
    a_read_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    a_test_reset: assert property (!trst_n [*6] |-> tdo_oe_n)
        else $error("test output driven in reset");
    a_tdo_on_fall: assert property ($changed(tdo) |-> !$past(tck, 2))
        else $error("test output moved off falling clock");
endmodule : sos_props

// ==== sim/sos_board.sv ====
// Board model: data link clock, data and octet group indication
`timescale 1ns/100ps
module sos_board (
    input  wire logic frame_go,
    output logic      rx_dl_clk,
    output logic      rx_dl_data,
    output logic      rx_dl_early_group,
    output logic      tx_dl_clk
);
    initial
    begin
        {rx_dl_clk, rx_dl_data, rx_dl_early_group, tx_dl_clk} = 4'h0;
    end
    // Eight bits per frame, clocks still between frames
    always @(posedge frame_go)
    begin
        #7;
        for (int i = 0; i < 8; i++)
        begin
            rx_dl_data = i[0] ^ i[1];
            rx_dl_early_group = (i < 3);
            #80 {rx_dl_clk, tx_dl_clk} = 2'b11;
            #80 {rx_dl_clk, tx_dl_clk} = 2'b00;
        end
        rx_dl_data = ~rx_dl_data;
        rx_dl_early_group = 1'b0;
    end
endmodule : sos_board

// ==== sim/tb.sv ====
// Testbench for the status output selector
`timescale 1ns/100ps
module tb;
    import sos_pkg::*;
    logic       clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, irq, tdo, tdo_oe_n;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, rv;
    logic       los_defect = 0, oof_defect = 0, lop_defect = 0, ais_line_defect = 0;
    logic       trst_n = 1, tck = 0, tms = 1, tdi = 0, frame_go = 0, p3, p0;
    logic       rx_dl_clk, rx_dl_data, rx_dl_early_group, tx_dl_clk;
    logic [3:0] status_pins;
    int         n_fail = 0, checks_done = 0, r3, r0;
    localparam logic [7:0] AD[5] = '{8'h00, 8'h02, 8'h0c, 8'h0d, 8'h46};
    // gen, out bits, tx section, tx line, rx line, defects, pins
    localparam logic [47:0] ROWS[9] = '{48'h00_f0_00_00_00_f_f, 48'h00_a0_00_00_00_3_a,
        48'h04_f0_00_00_00_5_5, 48'h04_00_00_00_00_a_a, 48'h04_00_00_00_01_f_1,
        48'h04_00_00_00_02_f_1, 48'h04_00_00_10_00_f_e, 48'h04_00_40_00_00_f_e,
        48'h00_f0_00_10_01_0_0};
    sos_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .los_defect(los_defect), .oof_defect(oof_defect),
        .lop_defect(lop_defect), .ais_line_defect(ais_line_defect), .rx_dl_clk(rx_dl_clk),
        .rx_dl_data(rx_dl_data), .rx_dl_early_group(rx_dl_early_group),
        .tx_dl_clk(tx_dl_clk), .status_pins(status_pins), .trst_n(trst_n), .tck(tck),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
    sos_board board_u (.frame_go(frame_go), .rx_dl_clk(rx_dl_clk), .rx_dl_data(rx_dl_data),
        .rx_dl_early_group(rx_dl_early_group), .tx_dl_clk(tx_dl_clk));
    initial
    begin
        forever #10 clk_sys = ~clk_sys;
    end
    // ----
    // Tasks
    // ----
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk_sys) reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk_sys) reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk_sys);
    endtask : rd
    task automatic tcyc(input logic m, input logic i);
        {tms, tdi} <= {m, i};
        repeat (3) @(posedge clk_sys);
        tck <= 1'b1;
        repeat (4) @(posedge clk_sys);
        tck <= 1'b0;
        repeat (5) @(posedge clk_sys);
    endtask : tcyc
    task automatic wrap_up;
        if (n_fail == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    initial
    begin
        #100000 n_fail++;
        wrap_up();
    end
    // ----
    // Main sequence
    // ----
    initial
    begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1 chk("pins_reset", status_pins, 4'h0);
        chk("oe_reset", tdo_oe_n, 1'b1);
        @(posedge clk_sys);
        foreach (AD[j])
        begin
            rd(AD[j], rv);
            chk("reg_reset", rv, 8'h00);
        end
        rd(8'h55, rv);
        chk("unmapped", rv, 8'h00);
        foreach (ROWS[k])
        begin
            foreach (AD[j]) wr(AD[j], ROWS[k][47 - 8 * j -: 8]);
            {los_defect, oof_defect, lop_defect, ais_line_defect} <= ROWS[k][7:4];
            repeat (4) @(posedge clk_sys);
            #1 chk("pins", status_pins, ROWS[k][3:0]);
            @(posedge clk_sys);
            foreach (AD[j])
            begin
                rd(AD[j], rv);
                chk("readback", rv, ROWS[k][47 - 8 * j -: 8]);
            end
        end
        {los_defect, oof_defect, lop_defect, ais_line_defect} <= 4'h0;
        foreach (AD[j]) wr(AD[j], 8'h00);
        wr(SOS_ADDR_IRQ_STATUS, 8'h0f);
        wr(SOS_ADDR_IRQ_MASK, 8'h08);
        {los_defect, oof_defect} <= 2'b11;
        repeat (6) @(posedge clk_sys);
        chk("irq_set", irq, 1'b1);
        rd(SOS_ADDR_IRQ_STATUS, rv);
        chk("irq_status", rv, 8'h0c);
        wr(SOS_ADDR_IRQ_STATUS, 8'h08);
        repeat (2) @(posedge clk_sys);
        chk("irq_clear", irq, 1'b0);
        rd(SOS_ADDR_IRQ_STATUS, rv);
        chk("irq_masked", rv, 8'h04);
        wr(SOS_ADDR_RX_LINE_CTRL, 8'h01);
        wr(SOS_ADDR_TX_LINE_CTRL, 8'h10);
        frame_go <= 1'b1;
        r3 = 0;
        r0 = 0;
        p3 = status_pins[3];
        p0 = status_pins[0];
        repeat (90)
        begin
            @(posedge clk_sys);
            #1 r3 += (status_pins[3] && !p3);
            r0 += (status_pins[0] && !p0);
            p3 = status_pins[3];
            p0 = status_pins[0];
        end
        chk("rx_clk_pulses", r3, 8);
        chk("tx_clk_pulses", r0, 8);
        @(posedge clk_sys);
        repeat (5) tcyc(1'b1, 1'b0);
        tcyc(1'b0, 1'b0);
        tcyc(1'b1, 1'b0);
        tcyc(1'b0, 1'b0);
        tcyc(1'b0, 1'b0);
        chk("oe_shift", tdo_oe_n, 1'b0);
        for (int i = 0; i < 33; i++)
        begin
            chk("scan_out", tdo, (i < 32) ? SOS_SCAN_IDCODE[i % 32] : 1'b1);
            tcyc(1'b0, i == 0);
        end
        rd(SOS_ADDR_SCAN_ID, rv);
        chk("tap_active", rv[0], 1'b0);
        trst_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk("oe_trst", tdo_oe_n, 1'b1);
        rd(SOS_ADDR_SCAN_ID, rv);
        chk("tap_reset", rv[0], 1'b1);
        trst_n <= 1'b1;
        wrap_up();
    end
endmodule : tb
bind sos_top sos_props chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .los_defect(los_defect), .oof_defect(oof_defect), .lop_defect(lop_defect),
    .ais_line_defect(ais_line_defect), .rx_dl_clk(rx_dl_clk), .rx_dl_data(rx_dl_data),
    .rx_dl_early_group(rx_dl_early_group), .tx_dl_clk(tx_dl_clk),
    .status_pins(status_pins), .trst_n(trst_n), .tck(tck), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
